// [core/mcs_pkg.sv]
// Purpose: Constants for the module configuration and sleep control block.
// Assumes: One 100 MHz clock, nibble-wide bus, 20-bit nibble addresses.
// Notes: Long counts are parameters of the top module.
// What this block does
// - Configuration runs at power-up, reset, and on any soft module change.
// - Fixed devices ignore configure, give no code, decode fixed ranges.
// - Identify answered only by the unconfigured device with chain input high.
// - Identification code carries the device size and its type.
// - A configured device raises its chain output for the next device.
// - Reset instruction unconfigures all devices; devices drop their address.
// - Module insertion or removal pulses the active-low interrupt line.
// - Address space is 20 nibble-address bits; system ROM at 00000-1FFFF.
// - Card reader 2C000-2C01F; display RAM 2E100-2E3FF and 2F400-2FFFF.
// - Top 1,023 nibbles are reserved for configuration, never mapped.
// - Awake: strobe runs at 600-650 kHz divided from the CPU clock.
// - Stop-clock parks strobe and select weakly high, bus weakly low.
// - Light sleep wakes every half second for the cursor, then resleeps.
// - Light sleep ends on key or service request, or 10 minutes idle.
// - Deep sleep powers the display off and wakes every four hours.
// - Deep sleep ends on insertion interrupt or on key; on key gives light.
// - Awake is entered on keyboard entry, interrupt or due alarm.
// - Wake timer runs from 32.768 kHz divided to 512 Hz, strobe independent.
// - Select high marks bus data, low marks a command.
package mcs_pkg;
	localparam int ADDR_W = 20;
	localparam logic [19:0] ROM_LO = 20'h00000;
	localparam logic [19:0] ROM_HI = 20'h1FFFF;
	localparam logic [19:0] CRD_LO = 20'h2C000;
	localparam logic [19:0] CRD_HI = 20'h2C01F;
	localparam logic [19:0] DSP1_LO = 20'h2E100;
	localparam logic [19:0] DSP1_HI = 20'h2E3FF;
	localparam logic [19:0] DSP2_LO = 20'h2F400;
	localparam logic [19:0] DSP2_HI = 20'h2FFFF;
	localparam logic [19:0] CFG_RSV_LO = 20'hFFC01;
	localparam logic [3:0] CMD_ID = 4'h1;
	localparam logic [3:0] CMD_CONFIG = 4'h2;
	localparam logic [3:0] CMD_RESET = 4'h3;
	localparam logic [1:0] TYPE_RAM = 2'h0;
	localparam logic [1:0] TYPE_ROM = 2'h1;
	localparam logic [1:0] TYPE_IO = 2'h2;
	localparam int CLK_HZ = 100_000_000;
	localparam int STROBE_HZ = 640_000;
	localparam int STROBE_HALF = CLK_HZ / (2 * STROBE_HZ);
	localparam int REF_HZ = 32_768;
	localparam int TICK_HZ = 512;
	localparam int REF_DIV = REF_HZ / TICK_HZ;
	localparam int HALF_SEC_MS = 500;
	localparam int IDLE_MIN = 10;
	localparam int DEEP_HOURS = 4;
	localparam int HALF_TICKS = TICK_HZ * HALF_SEC_MS / 1000;
	localparam int IDLE_TICKS = TICK_HZ * 60 * IDLE_MIN;
	localparam int DEEP_TICKS = TICK_HZ * 3600 * DEEP_HOURS;
	localparam int INT_PULSE = 4;
	typedef enum logic [1:0] {
		ST_AWAKE = 2'b00,
		ST_LIGHT = 2'b01,
		ST_DEEP = 2'b11
	} mcs_state_t;
endpackage

// [core/mcs_top.sv]
// Purpose: One soft-configured module slot plus system sleep control.
// Assumes: All inputs synchronous to clk_sys; ref_clk_in is sampled.
// Notes: Weak pull and precharge are shown by dropping the output enables.
`timescale 1ns/1ns
module mcs_top #(
	parameter int unsigned IDLE_LIMIT = mcs_pkg::IDLE_TICKS,
	parameter int unsigned DEEP_LIMIT = mcs_pkg::DEEP_TICKS,
	parameter logic [1:0] DEV_TYPE = mcs_pkg::TYPE_RAM,
	parameter logic [3:0] DEV_SIZE_LOG = 4'hC,
	parameter logic DEV_FIXED = 1'b0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_code,
	input wire logic [mcs_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic chain_in,
	output logic chain_out,
	output logic id_valid,
	output logic [5:0] id_code,
	input wire logic [mcs_pkg::ADDR_W-1:0] bus_addr,
	output logic sel_soft,
	output logic sel_sys_rom,
	output logic sel_card,
	output logic sel_display,
	input wire logic module_change,
	output logic int_n_out,
	output logic int_n_oe,
	input wire logic go_sleep,
	input wire logic key_event,
	input wire logic service_req,
	input wire logic on_key,
	input wire logic alarm_due,
	input wire logic irq_in,
	input wire logic cmd_phase,
	input wire logic ref_clk_in,
	output logic bus_strobe_out,
	output logic bus_strobe_oe,
	output logic command_data_select_out,
	output logic command_data_select_oe,
	output logic bus_oe,
	output logic lcd_power,
	output logic cpu_wake,
	output logic [1:0] power_state
);
	import mcs_pkg::*;

	// ------------------------------------------------------------
	// Reset release.
	// ------------------------------------------------------------
	logic rst_s1_r;
	logic rst_sync_n;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_sync_n <= rst_s1_r;
		end
	end

	// ------------------------------------------------------------
	// Configuration slave.
	// ------------------------------------------------------------
	logic cfg_r;
	logic [ADDR_W-1:0] base_r;
	logic [ADDR_W-1:0] span;
	logic id_hit;
	assign span = ADDR_W'(1) << DEV_SIZE_LOG;
	assign id_hit = cmd_valid && cmd_code == CMD_ID && chain_in && !cfg_r
		&& !DEV_FIXED;
	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			cfg_r <= 1'b0;
			base_r <= '0;
		end
		else if (cmd_valid && cmd_code == CMD_RESET)
		begin
			cfg_r <= 1'b0;
			base_r <= '0;
		end
		else if (cmd_valid && cmd_code == CMD_CONFIG && chain_in && !cfg_r
			&& !DEV_FIXED)
		begin
			cfg_r <= 1'b1;
			base_r <= cmd_addr;
		end
	end
	assign chain_out = DEV_FIXED ? chain_in : (chain_in && cfg_r);

	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			id_valid <= 1'b0;
			id_code <= '0;
		end
		else
		begin
			id_valid <= id_hit;
			id_code <= id_hit ? {DEV_TYPE, DEV_SIZE_LOG} : 6'h00;
		end
	end

	// ------------------------------------------------------------
	// Address decode.
	// ------------------------------------------------------------
	logic in_soft;
	assign in_soft = bus_addr >= base_r && (bus_addr - base_r) < span;
	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			sel_soft <= 1'b0;
			sel_sys_rom <= 1'b0;
			sel_card <= 1'b0;
			sel_display <= 1'b0;
		end
		else
		begin
			sel_soft <= cfg_r && in_soft && bus_addr < CFG_RSV_LO;
			sel_sys_rom <= bus_addr <= ROM_HI;
			sel_card <= bus_addr >= CRD_LO && bus_addr <= CRD_HI;
			sel_display <= (bus_addr >= DSP1_LO && bus_addr <= DSP1_HI)
				|| (bus_addr >= DSP2_LO && bus_addr <= DSP2_HI);
		end
	end

	// ------------------------------------------------------------
	// Module change interrupt.
	// ------------------------------------------------------------
	logic [2:0] int_cnt_r;
	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			int_cnt_r <= '0;
		else if (module_change)
			int_cnt_r <= 3'(INT_PULSE);
		else if (int_cnt_r != 3'h0)
			int_cnt_r <= int_cnt_r - 3'h1;
	end
	assign int_n_out = 1'b0;
	assign int_n_oe = int_cnt_r != 3'h0;

	// ------------------------------------------------------------
	// Wake timer base.
	// ------------------------------------------------------------
	logic ref_s1_r;
	logic ref_s2_r;
	logic ref_d_r;
	logic [5:0] ref_cnt_r;
	logic tick;
	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ref_s1_r <= 1'b0;
			ref_s2_r <= 1'b0;
			ref_d_r <= 1'b0;
			ref_cnt_r <= '0;
		end
		else
		begin
			ref_s1_r <= ref_clk_in;
			ref_s2_r <= ref_s1_r;
			ref_d_r <= ref_s2_r;
			if (ref_s2_r && !ref_d_r)
				ref_cnt_r <= ref_cnt_r + 6'h01;
		end
	end
	assign tick = ref_s2_r && !ref_d_r && ref_cnt_r == 6'(REF_DIV - 1);

	// ------------------------------------------------------------
	// Power state machine.
	// ------------------------------------------------------------
	mcs_state_t state_r;
	mcs_state_t state_nxt;
	logic [31:0] tmr_r;
	logic [31:0] idle_r;
	logic wake_evt;
	assign wake_evt = key_event || service_req || irq_in || alarm_due
		|| on_key;
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_AWAKE:
				if (go_sleep)
					state_nxt = ST_LIGHT;
			ST_LIGHT:
				if (wake_evt)
					state_nxt = ST_AWAKE;
				else if (tick && idle_r >= IDLE_LIMIT - 1)
					state_nxt = ST_DEEP;
			ST_DEEP:
				if (module_change || irq_in)
					state_nxt = ST_AWAKE;
				else if (on_key)
					state_nxt = ST_LIGHT;
			default:
				state_nxt = ST_AWAKE;
		endcase
	end
	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			state_r <= ST_AWAKE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			tmr_r <= '0;
			idle_r <= '0;
			cpu_wake <= 1'b0;
		end
		else
		begin
			cpu_wake <= 1'b0;
			if (state_nxt != state_r)
			begin
				tmr_r <= '0;
				if (state_nxt != ST_DEEP)
					idle_r <= '0;
			end
			else if (tick && state_r == ST_LIGHT)
			begin
				idle_r <= idle_r + 32'h1;
				if (tmr_r == 32'(HALF_TICKS - 1))
				begin
					tmr_r <= '0;
					cpu_wake <= 1'b1;
				end
				else
					tmr_r <= tmr_r + 32'h1;
			end
			else if (tick && state_r == ST_DEEP)
			begin
				if (tmr_r >= DEEP_LIMIT - 1)
				begin
					tmr_r <= '0;
					cpu_wake <= 1'b1;
				end
				else
					tmr_r <= tmr_r + 32'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Bus strobe and parking.
	// ------------------------------------------------------------
	logic [6:0] div_r;
	logic awake;
	logic awake_nxt;
	assign awake = state_r == ST_AWAKE;
	// The strobe and the select park on the same edge as the state change.
	assign awake_nxt = state_nxt == ST_AWAKE;
	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			div_r <= '0;
			bus_strobe_out <= 1'b1;
		end
		else if (!awake_nxt)
		begin
			div_r <= '0;
			bus_strobe_out <= 1'b1;
		end
		else if (div_r == 7'(STROBE_HALF - 1))
		begin
			div_r <= '0;
			bus_strobe_out <= !bus_strobe_out;
		end
		else
			div_r <= div_r + 7'h01;
	end
	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			command_data_select_out <= 1'b1;
		else
			command_data_select_out <= awake_nxt ? !cmd_phase : 1'b1;
	end
	assign bus_strobe_oe = awake;
	assign command_data_select_oe = awake;
	assign bus_oe = awake;
	assign lcd_power = state_r != ST_DEEP;
	assign power_state = state_r;
endmodule

// [tb/mcs_checker.sv]
// Purpose: Port checks for the configuration and sleep block.
// Assumes: Decode, interrupt-cause and strobe checks start once a settle counter saturates after reset.
// Notes: The strobe hold counter is only judged after long awake runs.
`timescale 1ns/1ns
module mcs_checker
	import mcs_pkg::*;
#(
	parameter logic [1:0] DEV_TYPE = mcs_pkg::TYPE_RAM,
	parameter logic [3:0] DEV_SIZE_LOG = 4'hC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_code,
	input wire logic chain_in,
	input wire logic chain_out,
	input wire logic id_valid,
	input wire logic [5:0] id_code,
	input wire logic [mcs_pkg::ADDR_W-1:0] bus_addr,
	input wire logic sel_soft,
	input wire logic sel_sys_rom,
	input wire logic sel_card,
	input wire logic module_change,
	input wire logic int_n_out,
	input wire logic int_n_oe,
	input wire logic bus_strobe_out,
	input wire logic bus_strobe_oe,
	input wire logic command_data_select_oe,
	input wire logic bus_oe,
	input wire logic lcd_power,
	input wire logic [1:0] power_state
);
	logic [7:0] rc_r;
	logic [7:0] aw_r;
	logic [7:0] hc_r;
	logic st_r;
	logic live;
	assign live = rc_r == 8'hC8;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rc_r <= 8'h00;
			aw_r <= 8'h00;
		end
		else
		begin
			rc_r <= live ? rc_r : rc_r + 8'h01;
			aw_r <= (power_state != 2'b00) ? 8'h00 : aw_r + {7'h00, ~&aw_r};
		end
	end
	always_ff @(posedge clk_sys)
	begin
		st_r <= bus_strobe_out;
		hc_r <= (bus_strobe_out != st_r) ? 8'h01 : hc_r + 8'h01;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	AST_ID_SRC: assert property (id_valid |-> $past(cmd_valid) &&
		$past(cmd_code) == CMD_ID && $past(chain_in) && !$past(chain_out))
		else $error("identify answer without cause");
	AST_ID_CODE: assert property (
		id_valid |-> id_code == {DEV_TYPE, DEV_SIZE_LOG})
		else $error("identify code wrong");
	AST_ROM: assert property (
		live |=> sel_sys_rom == ($past(bus_addr) <= ROM_HI))
		else $error("system rom decode wrong");
	AST_CARD: assert property (live |=> sel_card ==
		($past(bus_addr) >= CRD_LO && $past(bus_addr) <= CRD_HI))
		else $error("card decode wrong");
	AST_RSV: assert property (
		live && bus_addr >= CFG_RSV_LO |=> !sel_soft)
		else $error("reserved area selected");
	AST_INT_LEN: assert property ($rose(int_n_oe) |->
		(int_n_oe && !int_n_out) [*4] ##1 !int_n_oe)
		else $error("interrupt pulse length wrong");
	AST_INT_CAUSE: assert property (
		live && module_change |-> ##[1:2] int_n_oe)
		else $error("no interrupt pulse on change");
	AST_PARK: assert property (power_state != 2'b00 |->
		bus_strobe_out && !bus_strobe_oe && !command_data_select_oe && !bus_oe)
		else $error("bus not parked in sleep");
	AST_STROBE: assert property (live && aw_r == 8'hFF &&
		bus_strobe_out != st_r |-> hc_r == 8'(STROBE_HALF))
		else $error("strobe half period wrong");
	AST_LCD: assert property (
		lcd_power == (power_state != 2'b11))
		else $error("display power wrong for state");
endmodule
bind mcs_top mcs_checker #(.DEV_TYPE(DEV_TYPE), .DEV_SIZE_LOG(DEV_SIZE_LOG))
	u_chk (.*);

// [tb/mcs_up_dev.sv]
// Purpose: Earlier soft device on the chain that feeds chain_in.
// Assumes: Its own chain input is high, so it sits first on the chain.
// Notes: Its chain output is a driven level, never released.
`timescale 1ns/1ns
module mcs_up_dev (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_code,
	output logic chain_out
);
	import mcs_pkg::*;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			chain_out <= 1'b0;
		else if (cmd_valid && cmd_code == CMD_RESET)
			chain_out <= 1'b0;
		else if (cmd_valid && cmd_code == CMD_CONFIG)
			chain_out <= 1'b1;
	end
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the configuration and sleep block.
// Assumes: A fast stand-in reference clock shortens the sleep timers.
// Notes: Inputs change on the falling clock edge.
`timescale 1ns/1ns
module tb;
	import mcs_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic [3:0] cmd_code = 4'h0;
	logic [19:0] cmd_addr = 20'h00000;
	logic [19:0] bus_addr = 20'h40000;
	logic mod_chg = 1'b0;
	logic ref_clk = 1'b0;
	logic [5:0] ev = 6'h00;
	logic cph = 1'b0;
	logic chain_in, chain_out, id_valid, sel_soft, sel_rom, sel_card, sel_dsp;
	logic int_out, int_oe, stb, lcd, cd_out, wake;
	logic [5:0] id_code;
	logic [1:0] pst;
	int err_total = 0;
	int num_checks = 0;
	localparam int TICK_CYC = 2 * REF_DIV;
	localparam int IDLE_T = 260;
	localparam int DEEP_T = 10;
	initial forever #5 clk_sys = ~clk_sys;
	initial forever #10 ref_clk = ~ref_clk;
	mcs_up_dev up (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .chain_out(chain_in));
	mcs_top #(.IDLE_LIMIT(IDLE_T), .DEEP_LIMIT(DEEP_T),
		.DEV_SIZE_LOG(4'hC)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_addr(cmd_addr), .chain_in(chain_in),
		.chain_out(chain_out), .id_valid(id_valid), .id_code(id_code),
		.bus_addr(bus_addr), .sel_soft(sel_soft), .sel_sys_rom(sel_rom),
		.sel_card(sel_card), .sel_display(sel_dsp), .module_change(mod_chg),
		.int_n_out(int_out), .int_n_oe(int_oe), .go_sleep(ev[0]),
		.key_event(ev[1]), .service_req(ev[2]), .on_key(ev[3]),
		.alarm_due(ev[4]), .irq_in(ev[5]), .cmd_phase(cph),
		.ref_clk_in(ref_clk), .bus_strobe_out(stb), .bus_strobe_oe(),
		.command_data_select_out(cd_out),
		.command_data_select_oe(), .bus_oe(),
		.lcd_power(lcd), .cpu_wake(wake), .power_state(pst));
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(string nm, logic [19:0] exp, logic [19:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cmd(logic [3:0] c, logic [19:0] a);
		@(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_addr = a;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
	endtask
	task automatic probe(logic [19:0] a);
		@(negedge clk_sys);
		bus_addr = a;
		@(negedge clk_sys);
	endtask
	task automatic pulse(int i);
		@(negedge clk_sys);
		ev[i] = 1'b1;
		@(negedge clk_sys);
		ev[i] = 1'b0;
	endtask
	task automatic wait_ps(logic [1:0] s, int n);
		for (int k = 0; k < n && pst !== s; k++)
			@(negedge clk_sys);
		chk("power_state", 20'(s), 20'(pst));
		if (pst !== s)
			finish_test();
	endtask
	task automatic t_map();
		logic [19:0] a [8] = '{20'h00000, 20'h1FFFF, 20'h20000, 20'h2C01F,
			20'h2C020, 20'h2E0FF, 20'h2E100, 20'h2FFFF};
		foreach (a[i])
		begin
			probe(a[i]);
			chk("sel_rom", 20'(a[i] <= ROM_HI), 20'(sel_rom));
			chk("sel_card", 20'(a[i] >= CRD_LO && a[i] <= CRD_HI),
				20'(sel_card));
			chk("sel_dsp", 20'((a[i] >= DSP1_LO && a[i] <= DSP1_HI) ||
				a[i] >= DSP2_LO), 20'(sel_dsp));
		end
	endtask
	task automatic t_cfg();
		cmd(CMD_ID, 20'h00000);
		chk("id_valid", 20'h0, 20'(id_valid));
		cmd(CMD_CONFIG, 20'h40000);
		chk("chain_out", 20'h0, 20'(chain_out));
		cmd(CMD_ID, 20'h00000);
		chk("id_valid", 20'h1, 20'(id_valid));
		chk("id_code", {14'h0000, TYPE_RAM, 4'hC}, 20'(id_code));
		cmd(CMD_CONFIG, 20'h40000);
		chk("chain_out", 20'h1, 20'(chain_out));
		probe(20'h40FFF);
		chk("sel_soft", 20'h1, 20'(sel_soft));
		probe(20'h41000);
		chk("sel_soft", 20'h0, 20'(sel_soft));
		cmd(CMD_ID, 20'h00000);
		chk("id_valid", 20'h0, 20'(id_valid));
		cmd(CMD_RESET, 20'h00000);
		probe(20'h40000);
		chk("sel_soft", 20'h0, 20'(sel_soft));
		cmd(CMD_CONFIG, 20'h30000);
		cmd(CMD_CONFIG, 20'h30000);
		probe(20'h30000);
		chk("sel_soft", 20'h1, 20'(sel_soft));
		cmd(CMD_RESET, 20'h00000);
		cmd(CMD_CONFIG, 20'h20000);
		cmd(CMD_CONFIG, 20'h20000);
		probe(20'h20FFF);
		chk("sel_soft", 20'h1, 20'(sel_soft));
		cmd(CMD_RESET, 20'h00000);
		cmd(CMD_CONFIG, 20'hFEC00);
		cmd(CMD_CONFIG, 20'hFEC00);
		probe(20'hFFBFF);
		chk("sel_soft", 20'h1, 20'(sel_soft));
		probe(20'hFFC01);
		chk("sel_soft", 20'h0, 20'(sel_soft));
	endtask
	task automatic t_int();
		int n = 0;
		@(negedge clk_sys);
		mod_chg = 1'b1;
		@(negedge clk_sys);
		mod_chg = 1'b0;
		repeat (8)
		begin
			n += (int_oe === 1'b1 && int_out === 1'b0);
			@(negedge clk_sys);
		end
		chk("int_len", 20'h4, 20'(n));
	endtask
	task automatic t_cd();
		@(negedge clk_sys);
		cph = 1'b1;
		@(negedge clk_sys);
		chk("cd_cmd", 20'h0, 20'(cd_out));
		cph = 1'b0;
		@(negedge clk_sys);
		chk("cd_data", 20'h1, 20'(cd_out));
	endtask
	task automatic t_wake(int lo, int hi);
		int k = 0;
		while (k < hi && wake !== 1'b1)
		begin
			@(negedge clk_sys);
			k++;
		end
		chk("cpu_wake", 20'h1, 20'(wake));
		chk("wake_time", 20'h1, 20'(k > lo));
		if (wake !== 1'b1)
			finish_test();
	endtask
	task automatic t_sleep();
		int w [4] = '{1, 2, 4, 5};
		pulse(0);
		cph = 1'b1;
		@(negedge clk_sys);
		chk("strobe", 20'h1, 20'(stb));
		chk("cd_park", 20'h1, 20'(cd_out));
		cph = 1'b0;
		foreach (w[i])
		begin
			wait_ps(2'b01, 4);
			pulse(w[i]);
			wait_ps(2'b00, 10);
			pulse(0);
		end
		t_wake((HALF_TICKS - 1) * TICK_CYC,
			HALF_TICKS * TICK_CYC);
		chk("light", 20'h1, 20'(pst));
		wait_ps(2'b11, (IDLE_T + 1) * TICK_CYC);
		chk("lcd", 20'h0, 20'(lcd));
		t_wake((DEEP_T - 1) * TICK_CYC, DEEP_T * TICK_CYC);
		pulse(3);
		wait_ps(2'b01, 10);
		pulse(1);
		wait_ps(2'b00, 10);
		pulse(0);
		wait_ps(2'b11, (IDLE_T + 1) * TICK_CYC);
		@(negedge clk_sys);
		mod_chg = 1'b1;
		@(negedge clk_sys);
		mod_chg = 1'b0;
		wait_ps(2'b00, 10);
	endtask
	initial
	begin
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (300) @(negedge clk_sys);
		t_map();
		t_cfg();
		t_int();
		t_cd();
		t_sleep();
		finish_test();
	end
endmodule
